// file: adc_conv_model.sv
// Converter model answering each start with one result
`timescale 1ns/1ps
`include "adc_scan_defs.vh"

module adc_conv_model (
  input  wire                 sys_clk,
  input  wire                 conv_start,
  input  wire [3:0]           lat,
  input  wire [`SAMPLE_W-1:0] raw_val,
  output reg                  conv_done,
  output reg  [`SAMPLE_W-1:0] conv_raw
);
  reg [4:0] cnt_ff;

  initial begin
    conv_done = 1'b0;
    conv_raw = 14'h0000;
    cnt_ff = 5'h00;
  end

  always @(posedge sys_clk) begin
    conv_done <= 1'b0;
    // Result lines carry nothing valid outside the done cycle
    conv_raw <= ~conv_raw;
    if (conv_start)
      cnt_ff <= {1'b0, lat} + 5'h01;
    else if (cnt_ff != 5'h00)
      cnt_ff <= cnt_ff - 5'h01;
    if (cnt_ff == 5'h01) begin
      conv_done <= 1'b1;
      conv_raw <= raw_val;
    end
  end
endmodule // adc_conv_model

// file: adc_sample_fifo.v
// Acquisition data FIFO holding converted samples
`timescale 1ns/1ps
`include "adc_scan_defs.vh"

module adc_sample_fifo (
  input  wire                   sys_clk,
  input  wire                   rst_b,
  input  wire                   clr,
  input  wire                   wr_valid,
  input  wire [`SAMPLE_W+2:0]   wr_data,
  output wire                   wr_ready,
  output reg                    rd_valid,
  output reg  [`SAMPLE_W+2:0]   rd_data,
  input  wire                   rd_ready,
  output wire                   full,
  output wire                   empty
);

  reg [`SAMPLE_W+2:0] mem [0:`FIFO_DEPTH-1];
  reg [`FIFO_AW:0]    wr_ptr_ff;
  reg [`FIFO_AW:0]    rd_ptr_ff;
  wire                do_wr;
  wire                do_rd;

  assign full     = (wr_ptr_ff[`FIFO_AW] != rd_ptr_ff[`FIFO_AW]) &&
                    (wr_ptr_ff[`FIFO_AW-1:0] == rd_ptr_ff[`FIFO_AW-1:0]);
  assign empty    = (wr_ptr_ff == rd_ptr_ff);
  assign wr_ready = ~full;
  assign do_wr    = wr_valid & ~full;
  assign do_rd    = ~empty & (~rd_valid | rd_ready);

  always @(posedge sys_clk) begin
    if (do_wr) begin
      mem[wr_ptr_ff[`FIFO_AW-1:0]] <= wr_data;
    end
  end

  always @(posedge sys_clk) begin
    if (!rst_b || clr) begin
      wr_ptr_ff <= {(`FIFO_AW+1){1'b0}};
      rd_ptr_ff <= {(`FIFO_AW+1){1'b0}};
      rd_valid  <= 1'b0;
      rd_data   <= {(`SAMPLE_W+3){1'b0}};
    end else begin
      if (do_wr) begin
        wr_ptr_ff <= wr_ptr_ff + 1'b1;
      end
      if (do_rd) begin
        rd_data   <= mem[rd_ptr_ff[`FIFO_AW-1:0]];
        rd_valid  <= 1'b1;
        rd_ptr_ff <= rd_ptr_ff + 1'b1;
      end else if (rd_ready) begin
        rd_valid <= 1'b0;
      end
    end
  end

endmodule // adc_sample_fifo

// file: adc_scan_acquisition_control.v
// Acquisition sequencer: polled conversions and triggered timed scans
// Contract
// - Each sample is delivered as a 14-bit two's complement value.
// - Bipolar codes: 1FFF top, 0000 zero, 3FFF minus LSB, 2000 negative full scale.
// - Unipolar codes: 2000 at zero volts, 0000 midscale, 1FFF near full scale.
// - Each completed conversion is written into the acquisition data FIFO.
// - A timed acquisition waits until the selected trigger is detected.
// - Each software convert command starts exactly one conversion in polling mode.
// - A readable conversion-complete status; software reads data only once it is set.
// - Scans start at intervals set by the scan interval counter.
// - Samples within a scan are spaced by the sample interval count.
// - Channel list is ascending, may skip channels, repeats each scan.
// - Post-trigger mode starts scanning right after the trigger.
// - Delay-trigger mode starts scanning after the programmed delay.
// - Retrigger mode runs a new scan sequence on each later trigger.
// - Trigger source: software, external digital, analog or sync bus.
// - Channel, gain and polarity are programmable.
// - Scan interval, sample interval and post-scan count are 24 bits.
// - Delay counter counts down on its clock after trigger; scan starts at zero.
// - Triggers during a scan sequence are ignored.
`timescale 1ns/1ps
`include "adc_scan_defs.vh"

module adc_scan_acquisition_control (
  input  wire                  sys_clk,
  input  wire                  rst_b,
  input  wire                  scan_mode,
  input  wire [`CHAN_W-1:0]    poll_channel,
  input  wire [`GAIN_W-1:0]    gain_sel,
  input  wire                  unipolar,
  input  wire                  convert_cmd,
  input  wire                  arm,
  input  wire                  disarm,
  input  wire                  delay_mode,
  input  wire                  retrigger_en,
  input  wire [1:0]            trigger_source,
  input  wire                  software_trigger,
  input  wire                  external_digital_trigger,
  input  wire                  external_analog_trigger_input,
  input  wire                  sync_bus_trigger,
  input  wire                  delay_clk_tick,
  input  wire [`NUM_CHAN-1:0]  scan_channel_mask,
  input  wire [`CNT_W-1:0]     scan_interval_count,
  input  wire [`CNT_W-1:0]     sample_interval_count,
  input  wire [`CNT_W-1:0]     post_scan_count,
  input  wire [`DELAY_W-1:0]   trigger_delay_count,
  input  wire                  conv_done,
  input  wire [`SAMPLE_W-1:0]  conv_raw,
  input  wire                  fifo_clear,
  input  wire                  sample_read,
  output reg                   conv_start,
  output reg  [`CHAN_W-1:0]    conv_channel,
  output reg  [`GAIN_W-1:0]    conv_gain,
  output reg                   conv_unipolar,
  output reg                   conv_complete,
  output reg  [`SAMPLE_W-1:0]  sample_data,
  output reg  [`CHAN_W-1:0]    sample_channel,
  output reg                   busy,
  output reg                   armed,
  output reg                   fifo_overrun
);

  // ===================================================================
  // States
  localparam [2:0] ST_IDLE  = 3'h0;
  localparam [2:0] ST_WAIT  = 3'h1;
  localparam [2:0] ST_DELAY = 3'h2;
  localparam [2:0] ST_SCAN  = 3'h3;
  localparam [2:0] ST_CONV  = 3'h4;
  localparam [2:0] ST_GAP   = 3'h5;

  reg  [2:0]              state_ff;
  reg  [2:0]              nxt_state;
  reg  [`CNT_W-1:0]       si_cnt_ff;
  reg  [`CNT_W-1:0]       si2_cnt_ff;
  reg  [`CNT_W-1:0]       scans_ff;
  reg  [`DELAY_W-1:0]     dly_ff;
  reg  [`CHAN_W-1:0]      chan_ff;
  reg                     scan_conv_ff;

  // ===================================================================
  // Trigger selection and next channel search
  reg                     trig_sel;
  reg                     more_chan;
  reg  [`CHAN_W-1:0]      nxt_chan;
  reg  [`CHAN_W-1:0]      first_chan;
  wire [`SAMPLE_W-1:0]    coded;
  wire                    fifo_wr_ready;
  wire                    fifo_full;
  wire                    fifo_empty;
  wire                    fifo_rd_valid;
  wire [`SAMPLE_W+2:0]    fifo_rd_data;
  wire                    si_done;
  wire                    si2_done;

  always @* begin
    case (trigger_source)
      `TRG_SOFT:    trig_sel = software_trigger;
      `TRG_DIGITAL: trig_sel = external_digital_trigger;
      `TRG_ANALOG:  trig_sel = external_analog_trigger_input;
      `TRG_SYNC:    trig_sel = sync_bus_trigger;
      default:      trig_sel = 1'b0;
    endcase
  end

  // Ascending search: highest bit checked first so lowest match wins
  integer i;
  always @* begin
    more_chan  = 1'b0;
    nxt_chan   = {`CHAN_W{1'b0}};
    first_chan = {`CHAN_W{1'b0}};
    for (i = `NUM_CHAN-1; i >= 0; i = i - 1) begin
      if (scan_channel_mask[i]) begin
        first_chan = i[`CHAN_W-1:0];
      end
      if (scan_channel_mask[i] && (i > chan_ff)) begin
        more_chan = 1'b1;
        nxt_chan  = i[`CHAN_W-1:0];
      end
    end
  end

  // Unipolar offset-binary moved into the two's complement code space
  assign coded    = unipolar ? (conv_raw ^ `UNIPOLAR_FLIP) : conv_raw;
  assign si_done  = (si_cnt_ff <= 24'h000001);
  assign si2_done = (si2_cnt_ff <= 24'h000002);

  // ===================================================================
  // Sequencer
  always @* begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        if (!scan_mode && convert_cmd) begin
          nxt_state = ST_CONV;
        end else if (scan_mode && arm) begin
          nxt_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (disarm) begin
          nxt_state = ST_IDLE;
        end else if (trig_sel) begin
          nxt_state = delay_mode ? ST_DELAY : ST_SCAN;
        end
      end
      ST_DELAY: begin
        if (disarm) begin
          nxt_state = ST_IDLE;
        end else if (dly_ff == {`DELAY_W{1'b0}}) begin
          nxt_state = ST_SCAN;
        end
      end
      ST_SCAN: begin
        nxt_state = ST_CONV;
      end
      ST_CONV: begin
        if (conv_done) begin
          nxt_state = scan_conv_ff ? ST_GAP : ST_IDLE;
        end
      end
      ST_GAP: begin
        if (disarm) begin
          nxt_state = ST_IDLE;
        end else if (more_chan) begin
          if (si2_done) begin
            nxt_state = ST_SCAN;
          end
        end else if (scans_ff <= 24'h000001) begin
          nxt_state = retrigger_en ? ST_WAIT : ST_IDLE;
        end else if (si_done) begin
          nxt_state = ST_SCAN;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      state_ff      <= ST_IDLE;
      si_cnt_ff     <= {`CNT_W{1'b0}};
      si2_cnt_ff    <= {`CNT_W{1'b0}};
      scans_ff      <= {`CNT_W{1'b0}};
      dly_ff        <= {`DELAY_W{1'b0}};
      chan_ff       <= {`CHAN_W{1'b0}};
      scan_conv_ff  <= 1'b0;
      conv_start    <= 1'b0;
      conv_channel  <= {`CHAN_W{1'b0}};
      conv_gain     <= {`GAIN_W{1'b0}};
      conv_unipolar <= 1'b0;
      busy          <= 1'b0;
      armed         <= 1'b0;
    end else begin
      state_ff   <= nxt_state;
      conv_start <= 1'b0;
      busy       <= (nxt_state == ST_DELAY) || (nxt_state == ST_SCAN) ||
                    (nxt_state == ST_CONV) || (nxt_state == ST_GAP);
      armed      <= (nxt_state != ST_IDLE) && scan_mode;
      if (si_cnt_ff != {`CNT_W{1'b0}}) begin
        si_cnt_ff <= si_cnt_ff - 1'b1;
      end
      if (si2_cnt_ff != {`CNT_W{1'b0}}) begin
        si2_cnt_ff <= si2_cnt_ff - 1'b1;
      end
      case (state_ff)
        ST_IDLE: begin
          if (!scan_mode && convert_cmd) begin
            conv_start    <= 1'b1;
            scan_conv_ff  <= 1'b0;
            conv_channel  <= poll_channel;
            conv_gain     <= gain_sel;
            conv_unipolar <= unipolar;
          end
        end
        ST_WAIT: begin
          // Triggers are only looked at here, so those mid-sequence are dropped
          dly_ff   <= trigger_delay_count;
          scans_ff <= post_scan_count;
          chan_ff  <= first_chan;
          si_cnt_ff <= scan_interval_count;
        end
        ST_DELAY: begin
          if (delay_clk_tick && (dly_ff != {`DELAY_W{1'b0}})) begin
            dly_ff <= dly_ff - 1'b1;
          end
          si_cnt_ff <= scan_interval_count;
        end
        ST_SCAN: begin
          conv_start    <= 1'b1;
          scan_conv_ff  <= 1'b1;
          conv_channel  <= chan_ff;
          conv_gain     <= gain_sel;
          conv_unipolar <= unipolar;
          si2_cnt_ff    <= sample_interval_count;
        end
        ST_GAP: begin
          if (more_chan && si2_done) begin
            chan_ff <= nxt_chan;
          end else if (!more_chan && (scans_ff > 24'h000001) && si_done) begin
            chan_ff   <= first_chan;
            scans_ff  <= scans_ff - 1'b1;
            si_cnt_ff <= scan_interval_count;
          end
        end
        default: begin
        end
      endcase
    end
  end

  // ===================================================================
  // Result path: FIFO plus polled status
  adc_sample_fifo u_fifo (
    .sys_clk  (sys_clk),
    .rst_b    (rst_b),
    .clr      (fifo_clear),
    .wr_valid ((state_ff == ST_CONV) && conv_done),
    .wr_data  ({conv_channel, coded}),
    .wr_ready (fifo_wr_ready),
    .rd_valid (fifo_rd_valid),
    .rd_data  (fifo_rd_data),
    .rd_ready (sample_read),
    .full     (fifo_full),
    .empty    (fifo_empty)
  );

  always @(posedge sys_clk) begin
    if (!rst_b) begin
      conv_complete  <= 1'b0;
      sample_data    <= {`SAMPLE_W{1'b0}};
      sample_channel <= {`CHAN_W{1'b0}};
      fifo_overrun   <= 1'b0;
    end else begin
      // Status mirrors the FIFO head: set while data waits; after a read that pops a further word, data lags it one cycle
      conv_complete  <= fifo_rd_valid && !(sample_read && fifo_empty);
      sample_data    <= fifo_rd_data[`SAMPLE_W-1:0];
      sample_channel <= fifo_rd_data[`SAMPLE_W+2:`SAMPLE_W];
      if ((state_ff == ST_CONV) && conv_done && !fifo_wr_ready) begin
        fifo_overrun <= 1'b1;
      end else if (fifo_clear) begin
        fifo_overrun <= 1'b0;
      end
    end
  end

endmodule // adc_scan_acquisition_control

// file: adc_scan_acquisition_control_tb_top.sv
// Self-checking bench for the acquisition sequencer
`timescale 1ns/1ps
`include "adc_scan_defs.vh"

module adc_scan_acquisition_control_tb_top;
  reg sys_clk, rst_b, scan_mode, unipolar, convert_cmd, arm, disarm;
  reg delay_mode, retrigger_en, delay_clk_tick, fifo_clear, sample_read;
  reg [2:0] poll_channel;
  reg [1:0] gain_sel, trigger_source;
  reg [3:0] trg, lat;
  reg [7:0] scan_channel_mask;
  reg [23:0] scan_interval_count, sample_interval_count, post_scan_count;
  reg [15:0] trigger_delay_count;
  reg [13:0] raw_val;
  wire conv_done, conv_start, conv_unipolar, conv_complete, busy, armed, fifo_overrun;
  wire [13:0] conv_raw, sample_data;
  wire [2:0] conv_channel, sample_channel;
  wire [1:0] conv_gain;
  integer err_total, compares, cyc, n_st, i, s;
  integer st_t [0:15];
  reg [2:0] st_c [0:15];

  adc_scan_acquisition_control DUT (.sys_clk(sys_clk), .rst_b(rst_b), .scan_mode(scan_mode),
    .poll_channel(poll_channel), .gain_sel(gain_sel), .unipolar(unipolar), .convert_cmd(convert_cmd),
    .arm(arm), .disarm(disarm), .delay_mode(delay_mode), .retrigger_en(retrigger_en),
    .trigger_source(trigger_source), .software_trigger(trg[0]), .external_digital_trigger(trg[1]),
    .external_analog_trigger_input(trg[2]), .sync_bus_trigger(trg[3]), .delay_clk_tick(delay_clk_tick),
    .scan_channel_mask(scan_channel_mask), .scan_interval_count(scan_interval_count),
    .sample_interval_count(sample_interval_count), .post_scan_count(post_scan_count),
    .trigger_delay_count(trigger_delay_count), .conv_done(conv_done), .conv_raw(conv_raw),
    .fifo_clear(fifo_clear), .sample_read(sample_read), .conv_start(conv_start), .conv_channel(conv_channel),
    .conv_gain(conv_gain), .conv_unipolar(conv_unipolar), .conv_complete(conv_complete),
    .sample_data(sample_data), .sample_channel(sample_channel), .busy(busy), .armed(armed),
    .fifo_overrun(fifo_overrun));
  adc_conv_model cnv (.sys_clk(sys_clk), .conv_start(conv_start), .lat(lat), .raw_val(raw_val),
    .conv_done(conv_done), .conv_raw(conv_raw));

  initial begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end

  // ==========================================================
  // Start recorder and cycle ceiling
  always @(posedge sys_clk) begin
    if (conv_start === 1'b1 && n_st < 16) begin
      st_t[n_st] = cyc;
      st_c[n_st] = conv_channel;
      n_st = n_st + 1;
    end
    cyc = cyc + 1;
    if (cyc > 40000) begin
      err_total = err_total + 1;
      end_sim;
    end
  end

  // ==========================================================
  // Shared tasks
  task step(input integer n);
    repeat (n) @(negedge sys_clk);
  endtask

  task chk(input [8*8-1:0] nm, input [31:0] seen, input [31:0] exp);
    begin
      compares = compares + 1;
      if (seen !== exp) begin
        err_total = err_total + 1;
        $display("CHECK FAILED %0s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask

  task pop(input [13:0] ed, input [2:0] ec);
    integer w;
    begin
      w = 0;
      while (conv_complete !== 1'b1 && w < 200) begin
        step(1);
        w = w + 1;
      end
      chk("ready", conv_complete, 1'b1);
      chk("data", sample_data, ed);
      chk("chan", sample_channel, ec);
      sample_read = 1'b1;
      step(1);
      sample_read = 1'b0;
      step(3);
    end
  endtask

  task tick;
    begin
      delay_clk_tick = 1'b1;
      step(1);
      delay_clk_tick = 1'b0;
      step(9);
    end
  endtask

  task end_sim;
    begin
      $display("compares %0d mismatches %0d", compares, err_total);
      if (err_total == 0 && compares > 0)
        $display("verification passed");
      else
        $display("verification failed");
      $finish;
    end
  endtask

  // ==========================================================
  // Scenarios
  task t_poll;
    integer k;
    begin
      for (k = 0; k < 8; k = k + 1) begin
        raw_val = (k % 4 == 0) ? 14'h1FFF : (k % 4 == 1) ? 14'h0000 : (k % 4 == 2) ? 14'h3FFF : 14'h2000;
        unipolar = k[2];
        poll_channel = k;
        gain_sel = k;
        lat = k[0] ? 4'h9 : 4'h1;
        n_st = 0;
        // Odd passes hold the command into the busy cycle
        convert_cmd = 1'b1;
        step(k[0] ? 2 : 1);
        convert_cmd = 1'b0;
        chk("cfg", {conv_unipolar, conv_gain, conv_channel}, {k[2], k[1:0], k[2:0]});
        pop(k[2] ? raw_val ^ 14'h2000 : raw_val, k);
        chk("starts", n_st, 1);
        chk("empty", conv_complete, 1'b0);
      end
      $display("test poll done");
    end
  endtask

  task t_scan(input [1:0] src);
    integer tt;
    begin
      {scan_mode, unipolar, delay_mode, retrigger_en, lat} = {4'h8, 4'h2};
      trigger_source = src;
      scan_channel_mask = 8'h16;
      sample_interval_count = 24'h000064;
      scan_interval_count = 24'h000190;
      post_scan_count = 24'h000002;
      raw_val = 14'h0ABC;
      n_st = 0;
      arm = 1'b1;
      step(1);
      arm = 1'b0;
      trg = 4'hF ^ (4'h1 << src);
      step(20);
      chk("early", n_st, 0);
      tt = cyc;
      trg = 4'h1 << src;
      step(1);
      trg = 4'h0;
      step(1000);
      chk("count", n_st, 6);
      chk("lead", st_t[0] - tt, 2);
      chk("sample", st_t[1] - st_t[0], 100);
      chk("scan", st_t[3] - st_t[0], 400);
      chk("idle", armed, 1'b0);
      trg = 4'h1 << src;
      step(5);
      trg = 4'h0;
      chk("rearm", n_st, 6);
      for (i = 0; i < 6; i = i + 1) begin
        chk("order", st_c[i], 3'h1 << (i % 3));
        pop(14'h0ABC, 3'h1 << (i % 3));
      end
      $display("test scan done");
    end
  endtask

  task t_delay;
    integer j;
    begin
      {delay_mode, retrigger_en, trigger_source} = 4'hC;
      post_scan_count = 24'h000001;
      trigger_delay_count = 16'h0003;
      n_st = 0;
      arm = 1'b1;
      step(1);
      arm = 1'b0;
      step(2);
      for (j = 0; j < 2; j = j + 1) begin
        trg = 4'h1;
        step(1);
        trg = 4'h0;
        step(3);
        tick;
        // A trigger during the countdown must not restart it
        trg = 4'h1;
        step(1);
        trg = 4'h0;
        tick;
        chk("wait", n_st, 3 * j);
        chk("busy", busy, 1'b1);
        tick;
        step(5);
        chk("go", n_st, 3 * j + 1);
        step(300);
        chk("again", {armed, n_st[7:0]}, {1'b1, j[7:0] * 8'h03 + 8'h03});
        for (i = 0; i < 3; i = i + 1)
          pop(14'h0ABC, 3'h1 << i);
      end
      disarm = 1'b1;
      step(1);
      disarm = 1'b0;
      step(3);
      chk("disarm", armed, 1'b0);
      $display("test delay done");
    end
  endtask

  // One word sits in the output register, so 2050 results overflow 2048 entries
  task t_overrun;
    integer k;
    begin
      scan_mode = 1'b0;
      lat = 4'h1;
      for (k = 0; k < 2050; k = k + 1) begin
        convert_cmd = 1'b1;
        step(1);
        convert_cmd = 1'b0;
        step(4);
      end
      chk("overrun", fifo_overrun, 1'b1);
      fifo_clear = 1'b1;
      step(1);
      fifo_clear = 1'b0;
      step(3);
      chk("cleared", {fifo_overrun, conv_complete}, 2'b00);
      $display("test overrun done");
    end
  endtask

  // ==========================================================
  // Main sequence
  initial begin
    {rst_b, scan_mode, unipolar, convert_cmd, arm, disarm, delay_mode, retrigger_en} = 8'h00;
    {delay_clk_tick, fifo_clear, sample_read, poll_channel, gain_sel, trigger_source} = 10'h000;
    {trg, lat, scan_channel_mask, raw_val, trigger_delay_count} = 46'h0;
    {scan_interval_count, sample_interval_count, post_scan_count} = 72'h0;
    {err_total, compares, cyc, n_st} = 128'h0;
    step(6);
    rst_b = 1'b1;
    step(1);
    fifo_clear = 1'b1;
    step(1);
    fifo_clear = 1'b0;
    step(2);
    chk("overrun", fifo_overrun, 1'b0);
    t_poll;
    for (s = 0; s < 4; s = s + 1)
      t_scan(s);
    t_delay;
    t_overrun;
    end_sim;
  end
endmodule // adc_scan_acquisition_control_tb_top

// file: adc_scan_defs.vh
// Constants for the acquisition scan controller
`ifndef ADC_SCAN_DEFS_VH
`define ADC_SCAN_DEFS_VH

// =====================================================================
// Widths
`define SAMPLE_W          14
`define CNT_W             24
`define DELAY_W           16
`define CHAN_W            3
`define NUM_CHAN          8
`define GAIN_W            2
`define FIFO_AW           11
`define FIFO_DEPTH        2048

// =====================================================================
// Trigger sources
`define TRG_SOFT          2'h0
`define TRG_DIGITAL       2'h1
`define TRG_ANALOG        2'h2
`define TRG_SYNC          2'h3

// =====================================================================
// Codes and limits
`define UNIPOLAR_FLIP     14'h2000
`define MIN_SAMPLE_IVL    24'h000064

`endif

// file: adc_scan_props.sv
// Checker for the acquisition sequencer ports
`timescale 1ns/1ps
`include "adc_scan_defs.vh"

module adc_scan_props (
  input wire                 sys_clk,
  input wire                 rst_b,
  input wire                 scan_mode,
  input wire [`CHAN_W-1:0]   poll_channel,
  input wire [`GAIN_W-1:0]   gain_sel,
  input wire                 unipolar,
  input wire                 convert_cmd,
  input wire                 arm,
  input wire                 disarm,
  input wire [`NUM_CHAN-1:0] scan_channel_mask,
  input wire                 conv_done,
  input wire                 conv_start,
  input wire [`CHAN_W-1:0]   conv_channel,
  input wire [`GAIN_W-1:0]   conv_gain,
  input wire                 conv_unipolar,
  input wire                 conv_complete,
  input wire                 busy,
  input wire                 armed,
  input wire                 fifo_overrun
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Polled command that the idle sequencer must take
  wire poll_go = convert_cmd && !scan_mode && !armed && !busy;

  start_pulse_a: assert property (conv_start |=> !conv_start) else $error("start longer than one cycle");
  poll_start_a: assert property (poll_go |=> conv_start) else $error("command gave no start");
  start_cause_a: assert property (conv_start |-> $past(convert_cmd) || armed) else $error("start without cause");
  poll_cfg_a: assert property (poll_go |=> conv_channel == $past(poll_channel) && conv_gain == $past(gain_sel)
    && conv_unipolar == $past(unipolar)) else $error("conversion setup wrong");
  scan_list_a: assert property (conv_start && armed |-> scan_channel_mask[conv_channel]) else $error("channel off list");
  done_store_a: assert property (conv_done && busy |-> ##[1:4] (conv_complete || fifo_overrun))
    else $error("result not stored");
  arm_cause_a: assert property ($rose(armed) |-> $past(arm)) else $error("armed without arm");
  disarm_idle_a: assert property (disarm |-> ##[1:3] !armed) else $error("disarm not honoured");

  cover property (poll_go ##1 conv_start);
  cover property ($rose(armed));
  cover property (conv_start && armed);
endmodule // adc_scan_props

bind adc_scan_acquisition_control adc_scan_props u_props (.sys_clk(sys_clk), .rst_b(rst_b), .scan_mode(scan_mode),
  .poll_channel(poll_channel), .gain_sel(gain_sel), .unipolar(unipolar), .convert_cmd(convert_cmd), .arm(arm),
  .disarm(disarm), .scan_channel_mask(scan_channel_mask), .conv_done(conv_done), .conv_start(conv_start),
  .conv_channel(conv_channel), .conv_gain(conv_gain), .conv_unipolar(conv_unipolar),
  .conv_complete(conv_complete), .busy(busy), .armed(armed), .fifo_overrun(fifo_overrun));
